// ### hw/glue_regs.svh
// Constants for the processor bus decode glue: offsets, bits, resets and rates
`ifndef GLUE_REGS_SVH
`define GLUE_REGS_SVH

// ----------------------------------------
// Register map, byte addresses
// ----------------------------------------
`define OFF_CTRL       8'h00
`define OFF_LATCHES    8'h04
`define OFF_STATUS     8'h08
`define OFF_SWITCHES   8'h0C
`define OFF_ADDR       8'h10
`define CTRL_AUTO_ACQ  0
`define CTRL_LOCKED    1
`define CTRL_NARROW    2
`define CTRL_RST       3'h0

// ----------------------------------------
// Processor address map
// ----------------------------------------
`define RAM_TOP        16'h1FFF
`define RADIO_LO       16'hA170
`define RADIO_HI       16'hA172
`define PHONE_LO       16'hA0F0
`define PHONE_HI       16'hA0F2
`define BOARD_ADDR     16'hA1E7
`define PORT_A800      16'hA800
`define PORT_B000      16'hB000
`define PORT_B800      16'hB800
`define GROUP_MODEMS   3'h4

// ----------------------------------------
// Output latch bits and reset values
// ----------------------------------------
`define BIT_RTS        0
`define BIT_MOD_SEL    2
`define BIT_LOW_SPEED_TC 3
`define BIT_ACQ_FAST   6
`define LATCH_A800_RST 8'h00
`define LATCH_B000_RST 8'h45
`define LATCH_B800_RST 8'h00

// ----------------------------------------
// Rates
// ----------------------------------------
`define CLK_HZ                200000000
`define LOW_SPEED_BPS         150
`define HIGH_SPEED_WIDE_BPS   9600
`define HIGH_SPEED_NARROW_BPS 4800
`define LOW_SPEED_TICK_CYC    (`CLK_HZ / `LOW_SPEED_BPS)
`define HIGH_SPEED_WIDE_CYC   (`CLK_HZ / `HIGH_SPEED_WIDE_BPS)
`define HIGH_SPEED_NARROW_CYC (`CLK_HZ / `HIGH_SPEED_NARROW_BPS)

`endif

// ### hw/glue_pkg.sv
// Types shared by the processor bus decode glue
`default_nettype none
package glue_pkg;
	typedef logic [7:0] byte_type;

	typedef struct packed {
		logic ram;
		logic radio_modem;
		logic phone_modem;
		logic modem_board;
		logic sw_b800;
		logic sw_b000;
		logic sw_a800;
		logic latch_b800;
		logic latch_b000;
		logic latch_a800;
	} sel_type;

	typedef enum logic [1:0] {
		RESP_OKAY   = 2'h0,
		RESP_SLVERR = 2'h2
	} axi_resp_type;
endpackage
`default_nettype wire

// ### hw/glue_bus_if.sv
// Carrier between the glue core and its select decoder
`default_nettype none
interface glue_bus_if;
	import glue_pkg::*;
	logic [15:0] addr;
	logic        rd_n;
	logic        wr_n;
	sel_type     sel;
	modport decoder (input addr, input rd_n, input wr_n, output sel);
	modport core    (output addr, output rd_n, output wr_n, input sel);
endinterface
`default_nettype wire

// ### hw/rate_divider.sv
// Clock-enable divider producing one-cycle ticks at a run-time period
`default_nettype none
module rate_divider #(
	parameter int W = 24
)(
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Period in cycles and tick out
	input  wire logic [W-1:0] period,
	output logic              tick
);
	logic [W-1:0] cnt_reg;

	generate
		if (W < 2)
		begin : g_bad_width
			$error("rate_divider needs W of at least 2");
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_reg <= '0;
			tick    <= 1'b0;
		end
		else if (cnt_reg >= period - W'(1))
		begin
			cnt_reg <= '0;
			tick    <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_reg + W'(1);
			tick    <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### hw/addr_decoder.sv
// Strobe-qualified device select decoder
`default_nettype none
`include "glue_regs.svh"
module addr_decoder (
	// Decode bus
	glue_bus_if.decoder bus
);
	import glue_pkg::*;

	function automatic sel_type decode(input logic [15:0] a, input logic rd_n, input logic wr_n);
		sel_type s;
		logic    rd;
		logic    wr;
		s  = '0;
		// Both strobes low is illegal: enable nothing
		rd = !rd_n && wr_n;
		wr = !wr_n && rd_n;
		if (a <= `RAM_TOP)
			s.ram = rd | wr;
		else if (a[13:11] == `GROUP_MODEMS)
		begin
			s.radio_modem = (rd | wr) && a >= `RADIO_LO && a <= `RADIO_HI;
			s.phone_modem = (rd | wr) && a >= `PHONE_LO && a <= `PHONE_HI;
			s.modem_board = (rd | wr) && a == `BOARD_ADDR;
		end
		else
		begin
			s.sw_a800    = rd && a == `PORT_A800;
			s.sw_b000    = rd && a == `PORT_B000;
			s.sw_b800    = rd && a == `PORT_B800;
			s.latch_a800 = wr && a == `PORT_A800;
			s.latch_b000 = wr && a == `PORT_B000;
			s.latch_b800 = wr && a == `PORT_B800;
		end
		return s;
	endfunction

	always_comb
	begin
		bus.sel = decode(bus.addr, bus.rd_n, bus.wr_n);
	end
endmodule
`default_nettype wire

// ### hw/glue_top.sv
// Processor bus decode glue: address latch, selects, transceiver, latches
//
// The address map and the AXI4-Lite register port were decided locally.
`default_nettype none
`include "glue_regs.svh"
module glue_top #(
	parameter int LOW_SPEED_CYC         = `LOW_SPEED_TICK_CYC,
	parameter int HIGH_SPEED_WIDE_CYC   = `HIGH_SPEED_WIDE_CYC,
	parameter int HIGH_SPEED_NARROW_CYC = `HIGH_SPEED_NARROW_CYC
)(
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output glue_pkg::axi_resp_type     s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output glue_pkg::axi_resp_type     s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// Processor bus
	input  wire glue_pkg::byte_type    cpu_ad_in,
	output glue_pkg::byte_type         cpu_ad_out,
	output logic                       cpu_ad_oe,
	input  wire glue_pkg::byte_type    cpu_addr_hi,
	input  wire logic                  cpu_ale,
	input  wire logic                  program_fetch_strobe_n,
	input  wire logic                  cpu_rd_n,
	input  wire logic                  cpu_wr_n,
	output logic                       cpu_cts_n,
	output logic                       cpu_low_speed_rx,
	// Memories
	output logic [15:0]                mem_addr,
	output logic                       prog_oe_n,
	output logic                       ram_ce_n,
	output logic                       ram_oe_n,
	output logic                       ram_we_n,
	// Buffered data bus and peripherals
	input  wire glue_pkg::byte_type    buffered_data_bus_in,
	output glue_pkg::byte_type         buffered_data_bus_out,
	output logic                       buffered_data_bus_oe,
	output logic                       xcvr_to_cpu,
	output logic                       radio_modem_ce_n,
	output logic                       phone_modem_ce_n,
	output logic                       modem_board_ce_n,
	output logic [6:0]                 modem_board_addr,
	// Pins
	input  wire logic [23:0]           switch_closed,
	input  wire logic                  cts_n_pin,
	input  wire logic                  low_speed_rx_pin,
	// Station controls
	output logic [1:0]                 low_speed_data,
	output logic                       modulator_source_select,
	output logic                       high_speed_led_on,
	output logic                       high_speed_acq_fast,
	output logic                       rts_n,
	output logic                       low_speed_tc_slow,
	output logic                       low_speed_tick,
	output logic                       high_speed_tick
);
	import glue_pkg::*;

	generate
		if (LOW_SPEED_CYC < 2 || LOW_SPEED_CYC >= 2**24
			|| HIGH_SPEED_WIDE_CYC < 2 || HIGH_SPEED_WIDE_CYC >= 2**24
			|| HIGH_SPEED_NARROW_CYC < 2 || HIGH_SPEED_NARROW_CYC >= 2**24)
		begin : g_bad_rate
			$error("glue_top rate counts must lie in 2 .. 2**24-1");
		end
	endgenerate

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0]  cts_sync_reg;
	logic [1:0]  low_speed_sync_reg;
	logic [23:0] sw_meta_reg;
	logic [23:0] sw_sync_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cts_sync_reg       <= 2'h3;
			low_speed_sync_reg <= 2'h0;
			sw_meta_reg        <= 24'h000000;
			sw_sync_reg        <= 24'h000000;
		end
		else
		begin
			cts_sync_reg       <= {cts_sync_reg[0], cts_n_pin};
			low_speed_sync_reg <= {low_speed_sync_reg[0], low_speed_rx_pin};
			sw_meta_reg        <= switch_closed;
			sw_sync_reg        <= sw_meta_reg;
		end
	end

	assign cpu_cts_n        = cts_sync_reg[1];
	assign cpu_low_speed_rx = low_speed_sync_reg[1];

	// Pull-ups: an open switch reads one
	logic [23:0] sw_value;
	assign sw_value = ~sw_sync_reg;

	// ----------------------------------------
	// Address latch and memories
	// ----------------------------------------
	logic [7:0] addr_lo_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			addr_lo_reg <= 8'h00;
		else if (cpu_ale)
			addr_lo_reg <= cpu_ad_in;
	end

	assign mem_addr         = {cpu_addr_hi, addr_lo_reg};
	assign prog_oe_n        = program_fetch_strobe_n;
	assign modem_board_addr = addr_lo_reg[6:0];

	// ----------------------------------------
	// Select decode
	// ----------------------------------------
	glue_bus_if bus ();

	assign bus.addr = mem_addr;
	assign bus.rd_n = cpu_rd_n;
	assign bus.wr_n = cpu_wr_n;

	addr_decoder u_decoder (
		.bus (bus.decoder)
	);

	assign ram_ce_n         = !bus.sel.ram;
	assign ram_oe_n         = cpu_rd_n;
	assign ram_we_n         = cpu_wr_n;
	assign radio_modem_ce_n = !bus.sel.radio_modem;
	assign phone_modem_ce_n = !bus.sel.phone_modem;
	assign modem_board_ce_n = !bus.sel.modem_board;

	// ----------------------------------------
	// Transceiver
	// ----------------------------------------
	// Data is registered, so it is valid one cycle after the strobe falls
	assign xcvr_to_cpu          = !cpu_rd_n;
	assign cpu_ad_oe            = !cpu_rd_n;
	assign buffered_data_bus_oe = cpu_rd_n;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cpu_ad_out <= 8'h00;
		else if (!cpu_rd_n)
		begin
			if (bus.sel.sw_b800)
				cpu_ad_out <= sw_value[23:16];
			else if (bus.sel.sw_b000)
				cpu_ad_out <= sw_value[15:8];
			else if (bus.sel.sw_a800)
				cpu_ad_out <= sw_value[7:0];
			else
				cpu_ad_out <= buffered_data_bus_in;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			buffered_data_bus_out <= 8'h00;
		else if (!cpu_wr_n)
			buffered_data_bus_out <= cpu_ad_in;
	end

	// ----------------------------------------
	// Output latches
	// ----------------------------------------
	byte_type latch_a800_reg;
	byte_type latch_b000_reg;
	byte_type latch_b800_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			latch_a800_reg <= `LATCH_A800_RST;
			latch_b000_reg <= `LATCH_B000_RST;
			latch_b800_reg <= `LATCH_B800_RST;
		end
		else
		begin
			if (bus.sel.latch_a800)
				latch_a800_reg <= cpu_ad_in;
			if (bus.sel.latch_b000)
				latch_b000_reg <= cpu_ad_in;
			if (bus.sel.latch_b800)
				latch_b800_reg <= cpu_ad_in;
		end
	end

	logic [2:0] ctrl_reg;

	assign low_speed_data          = latch_b800_reg[1:0];
	assign modulator_source_select = latch_b000_reg[`BIT_MOD_SEL];
	assign high_speed_led_on       = !latch_b000_reg[`BIT_MOD_SEL];
	assign rts_n                   = latch_b000_reg[`BIT_RTS];
	assign low_speed_tc_slow       = latch_b000_reg[`BIT_LOW_SPEED_TC];

	// Auto mode lets software report lock instead of rewriting the latch
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			high_speed_acq_fast <= 1'b1;
		else if (ctrl_reg[`CTRL_AUTO_ACQ])
			high_speed_acq_fast <= !ctrl_reg[`CTRL_LOCKED];
		else
			high_speed_acq_fast <= latch_b000_reg[`BIT_ACQ_FAST];
	end

	// ----------------------------------------
	// Bit-rate enables
	// ----------------------------------------
	rate_divider #(.W(24)) u_low_speed_rate (
		.aclk    (aclk),
		.aresetn (aresetn),
		.period  (24'(LOW_SPEED_CYC)),
		.tick    (low_speed_tick)
	);

	rate_divider #(.W(24)) u_high_speed_rate (
		.aclk    (aclk),
		.aresetn (aresetn),
		.period  (ctrl_reg[`CTRL_NARROW] ? 24'(HIGH_SPEED_NARROW_CYC)
			: 24'(HIGH_SPEED_WIDE_CYC)),
		.tick    (high_speed_tick)
	);

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	function automatic logic reg_mapped(input logic [7:0] a);
		return a[7:2] <= `OFF_ADDR >> 2;
	endfunction

	logic        aw_got_reg;
	logic        w_got_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        aw_fire;
	logic        w_fire;
	logic        do_write;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;

	assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
	assign aw_fire       = s_axi_awvalid && s_axi_awready;
	assign w_fire        = s_axi_wvalid && s_axi_wready;
	assign do_write      = (aw_got_reg || aw_fire) && (w_got_reg || w_fire) && !s_axi_bvalid;
	assign wr_addr       = aw_got_reg ? aw_addr_reg : s_axi_awaddr;
	assign wr_data       = w_got_reg ? w_data_reg : s_axi_wdata;
	assign wr_strb       = w_got_reg ? w_strb_reg : s_axi_wstrb;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_reg   <= 1'b0;
			w_got_reg    <= 1'b0;
			aw_addr_reg  <= 8'h00;
			w_data_reg   <= 32'h00000000;
			w_strb_reg   <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else if (do_write)
		begin
			aw_got_reg   <= 1'b0;
			w_got_reg    <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= reg_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
		end
		else
		begin
			if (aw_fire)
			begin
				aw_got_reg  <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (w_fire)
			begin
				w_got_reg  <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_reg <= `CTRL_RST;
		else if (do_write && wr_addr[7:2] == `OFF_CTRL >> 2 && wr_strb[0])
			ctrl_reg <= wr_data[2:0];
	end

	logic [31:0] rd_word;

	always_comb
	begin
		unique case (s_axi_araddr[7:2])
			`OFF_CTRL >> 2:     rd_word = {29'h0, ctrl_reg};
			`OFF_LATCHES >> 2:  rd_word = {8'h00, latch_b800_reg, latch_b000_reg, latch_a800_reg};
			`OFF_STATUS >> 2:   rd_word = {28'h0, !rts_n && !cpu_cts_n, high_speed_acq_fast,
				cpu_low_speed_rx, cpu_cts_n};
			`OFF_SWITCHES >> 2: rd_word = {8'h00, sw_value};
			`OFF_ADDR >> 2:     rd_word = {16'h0000, mem_addr};
			default:            rd_word = 32'h00000000;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	fetch_only_strobe_a: assert property (!cpu_rd_n && program_fetch_strobe_n |-> prog_oe_n)
		else $error("Program memory enabled by data read");
	addr_capture_a: assert property (cpu_ale |=> mem_addr[7:0] == $past(cpu_ad_in))
		else $error("Low address not captured");
	addr_hold_a: assert property (!cpu_ale ##1 !cpu_ale |-> $stable(mem_addr[7:0]))
		else $error("Low address moved without strobe");
	xcvr_dir_a: assert property (!cpu_rd_n |-> xcvr_to_cpu && !buffered_data_bus_oe)
		else $error("Transceiver not turned toward processor");
	ram_window_a: assert property (!cpu_rd_n && cpu_wr_n && mem_addr <= `RAM_TOP |-> !ram_ce_n)
		else $error("RAM not selected in its window");
	one_select_a: assert property ($onehot0(bus.sel))
		else $error("More than one device selected");
	idle_no_select_a: assert property (cpu_rd_n && cpu_wr_n |-> bus.sel == '0)
		else $error("Device selected without a strobe");
	rts_latch_a: assert property (bus.sel.latch_b000 |=> rts_n == $past(cpu_ad_in[`BIT_RTS]))
		else $error("Request-to-send not loaded from latch");
	symbols_load_a: assert property (bus.sel.latch_b800 |=>
		low_speed_data == $past(cpu_ad_in[1:0]))
		else $error("Low-speed symbols not loaded");
	data_indicator_a: assert property (bus.sel.latch_b000 && !cpu_ad_in[`BIT_MOD_SEL] |=>
		high_speed_led_on)
		else $error("High-speed indicator dark while selected");
	locked_slow_a: assert property (ctrl_reg[`CTRL_AUTO_ACQ] && ctrl_reg[`CTRL_LOCKED]
		|=> !high_speed_acq_fast)
		else $error("Fast acquisition while locked");
	cts_sync_a: assert property ($fell(cts_sync_reg[0]) |=> !cpu_cts_n)
		else $error("Clear-to-send not passed on");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response dropped early");

	ram_read_c: cover property (!cpu_rd_n && !ram_ce_n);
	latch_write_c: cover property (bus.sel.latch_b000 ##1 !rts_n);
	axi_write_c: cover property (do_write ##1 s_axi_bvalid && s_axi_bready);
	axi_read_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

// ### verification/cpu_model.sv
// Processor-side model driving multiplexed address/data bus cycles
`default_nettype none
module cpu_model (
	// Clock
	input  wire logic          aclk,
	// Processor pins
	output glue_pkg::byte_type cpu_ad_in,
	output glue_pkg::byte_type cpu_addr_hi,
	output logic               cpu_ale,
	output logic               cpu_rd_n,
	output logic               cpu_wr_n
);
	timeunit 1ns;
	timeprecision 1ps;
	import glue_pkg::*;

	initial
	begin
		cpu_ad_in = 8'h00;
		cpu_addr_hi = 8'h00;
		cpu_ale = 1'b0;
		cpu_rd_n = 1'b1;
		cpu_wr_n = 1'b1;
	end

	// ----------------------------------------
	// Bus cycle
	// ----------------------------------------
	// Address phase first, then one strobe; high byte held throughout
	task automatic start(input logic [15:0] a, input logic rd, input byte_type d);
		@(posedge aclk);
		cpu_ad_in <= a[7:0];
		cpu_addr_hi <= a[15:8];
		cpu_ale <= 1'b1;
		@(posedge aclk);
		cpu_ale <= 1'b0;
		cpu_rd_n <= !rd;
		cpu_wr_n <= rd;
		// Released lines must not keep showing the address
		cpu_ad_in <= rd ? ~a[7:0] : d;
	endtask

	task automatic finish();
		@(posedge aclk);
		cpu_rd_n <= 1'b1;
		cpu_wr_n <= 1'b1;
		cpu_ad_in <= ~cpu_ad_in;
	endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the processor bus decode glue
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import glue_pkg::*;

	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, cpu_ale, program_fetch_strobe_n, cpu_rd_n, cpu_wr_n;
	logic cpu_cts_n, cpu_low_speed_rx, cpu_ad_oe, prog_oe_n, ram_ce_n, ram_oe_n, ram_we_n;
	logic buffered_data_bus_oe, xcvr_to_cpu, radio_modem_ce_n, phone_modem_ce_n;
	logic modem_board_ce_n, cts_n_pin, low_speed_rx_pin, modulator_source_select;
	logic high_speed_led_on, high_speed_acq_fast, rts_n, low_speed_tc_slow;
	logic low_speed_tick, high_speed_tick;
	logic [7:0]   s_axi_awaddr, s_axi_araddr;
	logic [31:0]  s_axi_wdata, s_axi_rdata;
	logic [3:0]   s_axi_wstrb;
	axi_resp_type s_axi_bresp, s_axi_rresp;
	byte_type     cpu_ad_in, cpu_ad_out, cpu_addr_hi;
	byte_type     buffered_data_bus_in, buffered_data_bus_out;
	logic [15:0]  mem_addr;
	logic [6:0]   modem_board_addr;
	logic [23:0]  switch_closed;
	logic [1:0]   low_speed_data;
	int           n_errors;
	int           tests_run;

	glue_top #(.LOW_SPEED_CYC(8), .HIGH_SPEED_WIDE_CYC(4), .HIGH_SPEED_NARROW_CYC(6)) dut (.*);
	cpu_model cpu (.*);

	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic final_report();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask

	// No slave latency assumed; a wait ends on the response or after 100 cycles
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit done;
		done = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 100 && !done; i++)
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1)
			begin
				chk("bresp", er, s_axi_bresp);
				s_axi_bready <= 1'b0;
				done = 1;
			end
		end
		if (!done)
		begin
			n_errors++;
			final_report();
		end
	endtask

	task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		bit done;
		done = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 100 && !done; i++)
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1)
			begin
				chk("rresp", er, s_axi_rresp);
				if (er == RESP_OKAY)
					chk("rdata", ed, s_axi_rdata);
				s_axi_rready <= 1'b0;
				done = 1;
			end
		end
		if (!done)
		begin
			n_errors++;
			final_report();
		end
	endtask

	task automatic cpu_write(input logic [15:0] a, input byte_type d);
		cpu.start(a, 1'b0, d);
		cpu.finish();
		#1;
	endtask

	// Counts over whole periods so the phase never matters
	task automatic tick_chk(input int n, input int el, input int eh);
		int l;
		int h;
		l = 0;
		h = 0;
		repeat (40) @(posedge aclk);
		repeat (n)
		begin
			@(posedge aclk);
			l += (low_speed_tick === 1'b1);
			h += (high_speed_tick === 1'b1);
		end
		chk("low_speed_tick count", el, l);
		chk("high_speed_tick count", eh, h);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk("rts_n", 1, rts_n);
		chk("high_speed_led_on", 0, high_speed_led_on);
		chk("high_speed_acq_fast", 1, high_speed_acq_fast);
		axi_read(8'h04, 32'h0000_4500, RESP_OKAY);
	endtask

	task automatic t_switches();
		logic [15:0] sa [3] = '{16'hB800, 16'hB000, 16'hA800};
		for (int i = 0; i < 3; i++)
		begin
			cpu.start(sa[i], 1'b1, 8'h00);
			#1;
			chk("xcvr_to_cpu", 1, xcvr_to_cpu);
			chk("cpu_ad_oe", 1, cpu_ad_oe);
			chk("buffered_oe", 0, buffered_data_bus_oe);
			chk("ram_ce_n", 1, ram_ce_n);
			chk("ram strobes", 2'b01, {ram_oe_n, ram_we_n});
			chk("prog_oe_n", 1, prog_oe_n);
			cpu.finish();
			#1;
			chk("switch byte", {24'h0, ~switch_closed[23-8*i -: 8]}, cpu_ad_out);
		end
		axi_read(8'h0C, {8'h00, ~switch_closed}, RESP_OKAY);
	endtask

	task automatic t_decode();
		logic [15:0] da [8] = '{16'h0000, 16'h1FFF, 16'hA170, 16'hA172,
			16'hA0F0, 16'hA0F2, 16'hA1E7, 16'hA173};
		logic [3:0] de [8] = '{4'h7, 4'h7, 4'hB, 4'hB, 4'hD, 4'hD, 4'hE, 4'hF};
		for (int i = 0; i < 8; i++)
		begin
			cpu.start(da[i], 1'b1, 8'h00);
			#1;
			chk("mem_addr", da[i], mem_addr);
			chk("board_addr", da[i][6:0], modem_board_addr);
			chk("selects", de[i], {ram_ce_n, radio_modem_ce_n,
				phone_modem_ce_n, modem_board_ce_n});
			cpu.finish();
			#1;
			chk("idle selects", 4'hF, {ram_ce_n, radio_modem_ce_n,
				phone_modem_ce_n, modem_board_ce_n});
			chk("bus read data", 8'hC3, cpu_ad_out);
		end
		axi_read(8'h10, 32'h0000_A173, RESP_OKAY);
		@(posedge aclk);
		program_fetch_strobe_n <= 1'b0;
		#1;
		chk("prog_oe_n", 0, prog_oe_n);
		@(posedge aclk);
		program_fetch_strobe_n <= 1'b1;
	endtask

	task automatic t_latches();
		cpu_write(16'hB000, 8'h48);
		chk("rts_n", 0, rts_n);
		chk("mod select", 0, modulator_source_select);
		chk("high_speed_led_on", 1, high_speed_led_on);
		chk("low_speed_tc_slow", 1, low_speed_tc_slow);
		chk("buffered_out", 8'h48, buffered_data_bus_out);
		cpu_write(16'hB000, 8'h05);
		@(posedge aclk);
		#1;
		chk("high_speed_acq_fast", 0, high_speed_acq_fast);
		cpu_write(16'hB800, 8'h03);
		chk("low_speed_data", 2'h3, low_speed_data);
		cpu_write(16'hA800, 8'h7E);
		axi_read(8'h04, 32'h0003_057E, RESP_OKAY);
	endtask

	task automatic t_modem();
		@(posedge aclk);
		cts_n_pin <= 1'b0;
		low_speed_rx_pin <= 1'b1;
		repeat (3) @(posedge aclk);
		#1;
		chk("cpu_cts_n", 0, cpu_cts_n);
		chk("cpu_low_speed_rx", 1, cpu_low_speed_rx);
		axi_read(8'h08, 32'h0000_0002, RESP_OKAY);
		cpu_write(16'hB000, 8'h44);
		axi_read(8'h08, 32'h0000_000E, RESP_OKAY);
	endtask

	task automatic t_ctrl();
		axi_write(8'h00, 32'h0000_0003, RESP_OKAY);
		axi_read(8'h00, 32'h0000_0003, RESP_OKAY);
		repeat (2) @(posedge aclk);
		#1;
		chk("acq locked", 0, high_speed_acq_fast);
		axi_write(8'h00, 32'h0000_0005, RESP_OKAY);
		repeat (2) @(posedge aclk);
		#1;
		chk("acq searching", 1, high_speed_acq_fast);
		tick_chk(120, 15, 20);
		axi_write(8'h00, 32'h0000_0001, RESP_OKAY);
		tick_chk(120, 15, 30);
		axi_read(8'h20, 32'h0, RESP_SLVERR);
		axi_write(8'h40, 32'h0, RESP_SLVERR);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		n_errors = 0;
		tests_run = 0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		program_fetch_strobe_n = 1'b1;
		buffered_data_bus_in = 8'hC3;
		switch_closed = 24'h5A3C81;
		cts_n_pin = 1'b1;
		low_speed_rx_pin = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_switches();
		t_decode();
		t_latches();
		t_modem();
		t_ctrl();
		final_report();
	end
endmodule
`default_nettype wire
